/* File: src/arp_master_map.vh */
`ifndef ARP_MASTER_MAP_VH
`define ARP_MASTER_MAP_VH
// Default device address used by every resolution command
`define ARP_DEF_ADDR      7'h61
// General command codes
`define ARP_CMD_PREPARE   8'h01
`define ARP_CMD_GETID     8'h03
`define ARP_CMD_ASSIGN    8'h04
// Expected byte count of an identifier read
`define ARP_ID_COUNT      8'h11
// Returned device address meaning "no valid address"
`define ARP_ADDR_INVALID  8'hFF
// Notify data field that asks for resolution
`define ARP_NOTIFY_REQ    16'h0000
// Identifier field positions of the address-type bits
`define ARP_ID_TYPE_HI    127
`define ARP_ID_TYPE_LO    126
// Clock rate in kHz
`define ARP_CLK_KHZ       10000
// Longest gap between identifier reads, in ms
`define ARP_GAP_MS        2000
// Hot-add rescan period, in s
`define ARP_PERIOD_S      10
// Derived cycle counts (longest times round down)
`define ARP_GAP_CYC       (`ARP_GAP_MS * `ARP_CLK_KHZ)
`define ARP_PERIOD_CYC    (`ARP_PERIOD_S * `ARP_CLK_KHZ * 1000)
// Retries for a refused prepare or assign
`define ARP_RETRIES       2
`endif

/* File: src/smbus_arp_master_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "arp_master_map.vh"

// Contract
// RL1: Slaves may notify after power-up or collision.
// RL2: Notify arrives at host address as slave.
// RL3: Only notify data 0x0000 requests resolution.
// RL4: Full run on working state, status change.
// RL5: Every full run starts with prepare.
// RL6: Optional identifier read every 10 seconds.
// RL7: Resolved devices ignore general identifier read.
// RL8: Prepare, then read/assign pairs until silence.
// RL9: At most two seconds between identifier reads.
// RL10: Pool loads fixed and reserved addresses.
// RL11: Refused prepare byte ends run, waits.
// RL12: With no devices, reissue prepare periodically.
// RL13: Read needs three acks and count 0x11.
// RL14: Address 0xFF gets a fresh unused address.
// RL15: Identifier type 00b keeps its fixed address.
// RL16: Pool hit gets fresh address, else kept.
// RL17: Assign carries the identifier just read.
// RL18: Refused assign byte: device absent, read again.
// RL19: Acked assign adds address, reads again.
// RL20: Idle: notify resumes at read, others pass.
// RL21: Pool addresses may drop on prepare rescan.
// RL22: Bus timeouts and retries are implemented.
// RL23: Commands go to default address 1100 001.
// RL24: Codes 0x01 prepare, 0x03 read, 0x04 assign.
// RL25: Read returns count, data and checksum.
// RL26: Slave refuses assign checksum on mismatch.
// RL27: Pool is one flag per address, lowest free.
module smbus_arp_master_sequencer #(
  parameter [127:0] FIXED_MASK = 128'h0,       // Known fixed-address devices
  parameter [127:0] RSVD_MASK  = 128'h0,       // Reserved addresses
  parameter         PERIODIC_EN = 1,           // Hot-add rescans enabled
  parameter [31:0]  GAP_CYC    = `ARP_GAP_CYC,    // Read-to-read bound
  parameter [31:0]  PERIOD_CYC = `ARP_PERIOD_CYC, // Rescan period
  parameter [1:0]   RETRIES    = `ARP_RETRIES     // Retries per packet
) (
  input  wire         core_clk,     // System clock
  input  wire         rst,          // Synchronous reset, active high
  input  wire         workState,    // Async: system is in working state
  input  wire         statusChange, // Async: device added or removed
  output wire         txValid,      // Request to bus engine
  input  wire         txReady,      // Engine takes request
  output reg  [7:0]   txCmd,        // Command code
  output wire [6:0]   txAddr,       // Target address
  output reg  [127:0] txUdid,       // Identifier for assign
  output reg  [7:0]   txNewAddr,    // Assigned address byte
  input  wire         rxDone,       // Engine finished, one cycle
  input  wire         rxAllAck,     // Every byte acknowledged
  input  wire         rxFirst3Ack,  // First three bytes acknowledged
  input  wire [7:0]   rxCount,      // Returned byte count
  input  wire         rxPecOk,      // Returned checksum matched
  input  wire [127:0] rxUdid,       // Returned identifier
  input  wire [7:0]   rxDevAddr,    // Returned device address byte
  input  wire         pktValid,     // Received host packet
  output wire         pktReady,     // Packet taken
  input  wire         pktNotify,    // Packet is the notify command
  input  wire [15:0]  pktData,      // Notify data field
  output reg          pktPass,      // Packet to normal processing
  output reg          busy,         // Run in progress
  output reg          runDone,      // Run ended, one cycle
  output reg          runAbort,     // Run ended on timeout, one cycle
  output reg          assignDone,   // Address assigned, one cycle
  output reg  [6:0]   assignAddr,   // Address just assigned
  output reg  [127:0] usedPool      // Used-address pool flags
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [7:0] S_IDLE = 8'h01; // Wait for packets or events
  localparam [7:0] S_PREP = 8'h02; // Offer prepare
  localparam [7:0] S_PRW  = 8'h04; // Prepare in flight
  localparam [7:0] S_GET  = 8'h08; // Offer identifier read
  localparam [7:0] S_GTW  = 8'h10; // Read in flight
  localparam [7:0] S_PICK = 8'h20; // Choose address
  localparam [7:0] S_ASG  = 8'h40; // Offer assign
  localparam [7:0] S_ASW  = 8'h80; // Assign in flight

  reg [7:0]   state_q;    // Current state
  reg [7:0]   state_d;    // Next state
  reg [1:0]   tries_q;    // Retries used
  reg [31:0]  gapCnt_q;   // Cycles since last read or prepare
  reg [31:0]  perCnt_q;   // Idle cycles toward rescan
  reg         anyRes_q;   // A device was resolved since last prepare
  reg         runReq_q;   // Full run pending
  reg [7:0]   devAddr_q;  // Captured device address byte
  reg [6:0]   freeAddr;   // Lowest clear pool flag
  reg         freeOk;     // Pool has a clear flag
  reg [6:0]   pickAddr;   // Chosen address
  reg         pickOk;     // Choice available
  integer     i;          // Scan index

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  reg [2:0] workSync_q;  // Stage 0 read only by stage 1
  reg [2:0] chgSync_q;   // Stage 0 read only by stage 1

  // Two flops then an edge-detect stage
  always @(posedge core_clk) begin
    if (rst) begin
      workSync_q <= 3'h0;
      chgSync_q  <= 3'h0;
    end else begin
      workSync_q <= {workSync_q[1:0], workState};
      chgSync_q  <= {chgSync_q[1:0], statusChange};
    end
  end

  wire workRise = workSync_q[1] & ~workSync_q[2]; // Entered working state
  wire chgEdge  = chgSync_q[1] ^ chgSync_q[2];    // Either edge counts

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes

  // Offer states drive the engine; default address always
  assign txValid  = (state_q == S_PREP) | (state_q == S_GET) |
                    (state_q == S_ASG);
  assign txAddr   = `ARP_DEF_ADDR; // RL23
  // Packets are only looked at while idle with no run pending
  assign pktReady = (state_q == S_IDLE) & ~runReq_q; // RL20 RL2

  wire pktTake  = pktValid & pktReady;
  // Reserved notify data is not a request
  wire notifyOk = pktNotify & (pktData == `ARP_NOTIFY_REQ); // RL3 RL1
  wire gapOver  = (gapCnt_q >= GAP_CYC - 32'h1); // RL9 RL22
  wire perOver  = (perCnt_q >= PERIOD_CYC - 32'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Address choice: lowest clear pool flag, or the device's own address

  // Scan from the top so the lowest clear flag wins
  always @* begin
    freeAddr = 7'h00;
    freeOk   = 1'b0;
    for (i = 127; i >= 0; i = i - 1) begin
      if (!usedPool[i]) begin
        freeAddr = i[6:0]; // RL27
        freeOk   = 1'b1;
      end
    end
  end

  // Fixed keeps its address, invalid or taken gets a fresh one
  always @* begin
    pickAddr = devAddr_q[7:1];
    pickOk   = 1'b1;
    if (devAddr_q == `ARP_ADDR_INVALID) begin
      pickAddr = freeAddr; // RL14
      pickOk   = freeOk;
    end else if (txUdid[`ARP_ID_TYPE_HI:`ARP_ID_TYPE_LO] == 2'b00) begin
      pickAddr = devAddr_q[7:1]; // RL15
    end else if (usedPool[devAddr_q[7:1]]) begin
      pickAddr = freeAddr; // RL16
      pickOk   = freeOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (runReq_q) begin
          state_d = S_PREP; // RL4 RL5
        end else if (pktTake && notifyOk) begin
          state_d = S_GET; // RL20
        end else if (PERIODIC_EN != 0 && perOver) begin
          // No devices known: prepare again; else a plain read
          state_d = anyRes_q ? S_GET : S_PREP; // RL6 RL12
        end
      end
      S_PREP: state_d = gapOver ? S_IDLE : (txReady ? S_PRW : S_PREP);
      S_PRW: begin
        if (gapOver) begin
          state_d = S_IDLE;
        end else if (rxDone) begin
          if (rxAllAck) begin
            state_d = S_GET; // RL8
          end else if (tries_q != RETRIES) begin
            state_d = S_PREP; // RL22
          end else begin
            state_d = S_IDLE; // RL11
          end
        end
      end
      S_GET: begin
        if (gapOver) begin
          state_d = S_IDLE;
        end else if (txReady) begin
          state_d = S_GTW;
        end
      end
      S_GTW: begin
        if (gapOver) begin
          state_d = S_IDLE;
        end else if (rxDone) begin
          // Silence or a bad answer ends enumeration
          if (rxFirst3Ack && rxCount == `ARP_ID_COUNT && rxPecOk) begin
            state_d = S_PICK; // RL13 RL25
          end else begin
            state_d = S_IDLE; // RL13 RL8
          end
        end
      end
      S_PICK: state_d = pickOk ? S_ASG : S_IDLE;
      S_ASG: begin
        if (gapOver) begin
          state_d = S_IDLE;
        end else if (txReady) begin
          state_d = S_ASW;
        end
      end
      S_ASW: begin
        if (gapOver) begin
          state_d = S_IDLE;
        end else if (rxDone) begin
          if (rxAllAck) begin
            state_d = S_GET; // RL19
          end else if (tries_q != RETRIES) begin
            state_d = S_ASG; // RL22
          end else begin
            state_d = S_GET; // RL18 RL26
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers

  // State, retries, timers and captured answer
  always @(posedge core_clk) begin
    if (rst) begin
      state_q   <= S_IDLE;
      tries_q   <= 2'h0;
      gapCnt_q  <= 32'h0;
      perCnt_q  <= 32'h0;
      devAddr_q <= 8'h00;
      txCmd     <= 8'h00;
      txUdid    <= 128'h0;
      txNewAddr <= 8'h00;
    end else begin
      state_q <= state_d;
      // Retry count restarts whenever a new packet kind is offered
      if (state_d == S_GET || state_q == S_PICK || state_q == S_IDLE) begin
        tries_q <= 2'h0;
      end else if ((state_q == S_PRW || state_q == S_ASW) && rxDone &&
                   !rxAllAck && tries_q != RETRIES) begin
        tries_q <= tries_q + 2'h1; // RL22
      end
      // Gap timer restarts on each read or prepare taken
      if (state_q == S_IDLE || (txValid && txReady && txCmd !=
          `ARP_CMD_ASSIGN)) begin
        gapCnt_q <= 32'h0; // RL9
      end else begin
        gapCnt_q <= gapCnt_q + 32'h1;
      end
      if (state_q != S_IDLE) begin
        perCnt_q <= 32'h0;
      end else if (!perOver) begin
        perCnt_q <= perCnt_q + 32'h1; // RL6
      end
      // Command code follows the state being entered
      if (state_d == S_PREP) begin
        txCmd <= `ARP_CMD_PREPARE; // RL24
      end else if (state_d == S_GET) begin
        txCmd <= `ARP_CMD_GETID; // RL24
      end else if (state_d == S_ASG) begin
        txCmd <= `ARP_CMD_ASSIGN; // RL24
      end
      // Keep the identifier exactly as returned
      if (state_q == S_GTW && rxDone) begin
        txUdid    <= rxUdid; // RL17
        devAddr_q <= rxDevAddr;
      end
      if (state_q == S_PICK) begin
        txNewAddr <= {pickAddr, 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pool and run bookkeeping

  // Pool reloads at each prepare, so absent devices drop out
  always @(posedge core_clk) begin
    if (rst) begin
      usedPool <= FIXED_MASK | RSVD_MASK; // RL10
      anyRes_q <= 1'b0;
      runReq_q <= 1'b0;
    end else begin
      if (state_q == S_PREP && txReady) begin
        usedPool <= FIXED_MASK | RSVD_MASK; // RL21 RL10
        anyRes_q <= 1'b0;
      end else if (state_q == S_ASW && rxDone && rxAllAck) begin
        usedPool[txNewAddr[7:1]] <= 1'b1; // RL19
        anyRes_q <= 1'b1;
      end
      // A new event wins over the clear of the same cycle
      if (workRise || chgEdge) begin
        runReq_q <= 1'b1; // RL4
      end else if (state_q == S_IDLE) begin
        runReq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  // All status outputs are registered
  always @(posedge core_clk) begin
    if (rst) begin
      busy       <= 1'b0;
      runDone    <= 1'b0;
      runAbort   <= 1'b0;
      assignDone <= 1'b0;
      assignAddr <= 7'h00;
      pktPass    <= 1'b0;
    end else begin
      busy       <= (state_d != S_IDLE);
      runDone    <= (state_q != S_IDLE) && (state_d == S_IDLE);
      runAbort   <= (state_q != S_IDLE) && (state_q != S_PICK) && gapOver;
      assignDone <= (state_q == S_ASW) && rxDone && rxAllAck;
      if (state_q == S_ASW && rxDone && rxAllAck) begin
        assignAddr <= txNewAddr[7:1];
      end
      // Anything but a valid notify goes to normal processing
      pktPass    <= pktTake && !notifyOk; // RL20
    end
  end

endmodule // smbus_arp_master_sequencer

`default_nettype wire

/* File: test/arp_far_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus engine plus one resolvable slave behind it
module arp_far_end_model (
  input wire logic          core_clk,   // Clock
  input wire logic          rst,        // Sync reset
  input wire logic [7:0]    lat,        // Answer delay, cycles
  input wire logic          devOn,      // Slave present
  input wire logic [127:0]  devId,      // Slave identifier
  input wire logic [7:0]    devAddr,    // Slave address byte
  input wire logic          badCount,   // Return a wrong count
  input wire logic          nackAssign, // Refuse assign checksum
  input wire logic          txValid,    // Offer
  input wire logic [7:0]    txCmd,      // Command
  input wire logic [6:0]    txAddr,     // Target
  input wire logic [127:0]  txUdid,     // Identifier sent
  output var logic          txReady,    // Accept
  output var logic          rxDone,     // Answer pulse
  output var logic          rxAllAck,   // All acked
  output var logic          rxFirst3Ack, // Read acked
  output var logic [7:0]    rxCount,    // Byte count
  output var logic          rxPecOk,    // Checksum good
  output var logic [127:0]  rxUdid,     // Identifier read
  output var logic [7:0]    rxDevAddr   // Address read
);
  logic [1:0] st_q;  // Idle, ready, answering
  logic [7:0] cnt_q; // Delay counter
  logic [7:0] cmd_q; // Accepted command
  logic       res_q; // Slave resolved
  wire        hit = devOn && txAddr == 7'h61;
  //////////////////////////////////////////////////////////////
  // Count, identifier and address lines flip outside an answer so stale data never helps
  always @(posedge core_clk) begin
    rxDone <= 1'b0;
    rxCount <= ~rxCount;
    rxUdid <= ~rxUdid;
    rxDevAddr <= ~rxDevAddr;
    if (rst) begin
      st_q <= 2'h0;
      cnt_q <= 8'h00;
      txReady <= 1'b0;
      res_q <= 1'b0;
      {rxCount, rxUdid, rxDevAddr} <= '0;
    end else if (st_q == 2'h0) begin
      cnt_q <= txValid ? cnt_q + 8'h01 : 8'h00;
      if (txValid && cnt_q >= lat) begin
        txReady <= 1'b1;
        st_q <= 2'h1;
      end
    end else if (st_q == 2'h1) begin
      txReady <= 1'b0;
      cmd_q <= txCmd;
      cnt_q <= 8'h00;
      st_q <= 2'h2;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q >= lat) begin
        st_q <= 2'h0;
        cnt_q <= 8'h00;
        rxDone <= 1'b1;
        rxAllAck <= hit && (cmd_q != 8'h04 ||
          (txUdid == devId && !nackAssign));
        rxFirst3Ack <= hit && !res_q;
        rxCount <= badCount ? 8'h10 : 8'h11;
        rxPecOk <= 1'b1;
        rxUdid <= devId;
        rxDevAddr <= devAddr;
        // A refused assign stands for a slave pulled out
        if (cmd_q == 8'h01) res_q <= 1'b0;
        if (cmd_q == 8'h04 && hit) res_q <= 1'b1;
      end
    end
  end
endmodule // arp_far_end_model
`default_nettype wire

/* File: test/arp_seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module arp_seq_checker #(
  parameter [127:0] FIXED_MASK = 128'h0, // Fixed devices
  parameter [127:0] RSVD_MASK  = 128'h0, // Reserved addresses
  parameter [31:0]  GAP_CYC    = 200     // Read-to-read bound
) (
  input wire logic         core_clk,    // Clock
  input wire logic         rst,         // Sync reset
  input wire logic         txValid,     // Offer
  input wire logic         txReady,     // Accept
  input wire logic [7:0]   txCmd,       // Command
  input wire logic [6:0]   txAddr,      // Target
  input wire logic [127:0] txUdid,      // Identifier
  input wire logic         rxDone,      // Answer
  input wire logic         rxAllAck,    // All acked
  input wire logic         rxFirst3Ack, // Read acked
  input wire logic [7:0]   rxCount,     // Byte count
  input wire logic         rxPecOk,     // Checksum good
  input wire logic         pktValid,    // Packet
  input wire logic         pktReady,    // Packet taken
  input wire logic         pktNotify,   // Notify packet
  input wire logic [15:0]  pktData,     // Notify data
  input wire logic         pktPass,     // Passed on
  input wire logic         busy,        // Run active
  input wire logic         runDone,     // Run end
  input wire logic         runAbort,    // Timeout end
  input wire logic         assignDone,  // Assigned
  input wire logic [6:0]   assignAddr,  // New address
  input wire logic [127:0] usedPool     // Pool
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0]  lastCmd_q; // Last accepted command
  logic [31:0] gap_q;     // Cycles since prepare or read
  logic        run_q;     // First offer of run taken
  wire         take = txValid && txReady;
  wire         pkt = pktValid && pktReady;
  //////////////////////////////////////////////////////////////
  // Gap only counts once the run has put something on the bus
  always @(posedge core_clk) begin
    lastCmd_q <= rst ? 8'h00 : (take ? txCmd : lastCmd_q);
    run_q <= !rst && busy && (run_q || take);
    if (!run_q || (take && txCmd != 8'h04))
      gap_q <= 32'h0;
    else
      gap_q <= gap_q + 32'h1;
  end
  chk_addr_default: assert property (txValid |-> txAddr == 7'h61)
    else $error("Offer not aimed at default address");
  chk_offer_hold: assert property (txValid && !txReady |=>
    runAbort || (txValid && $stable(txCmd) && $stable(txUdid)))
    else $error("Offer changed before accept");
  chk_pool_base: assert property ($fell(rst) |->
    usedPool == (FIXED_MASK | RSVD_MASK))
    else $error("Pool not loaded with base set");
  chk_prep_read: assert property (rxDone && busy &&
    lastCmd_q == 8'h01 && rxAllAck |=> txValid && txCmd == 8'h03)
    else $error("No read after acked prepare");
  chk_bad_read: assert property (rxDone && busy && lastCmd_q ==
    8'h03 && !(rxFirst3Ack && rxCount == 8'h11) |-> ##[1:2] runDone)
    else $error("Bad read did not end run");
  chk_good_read: assert property (rxDone && busy &&
    lastCmd_q == 8'h03 && rxFirst3Ack && rxCount == 8'h11 && rxPecOk
    |-> ##[1:4] (txValid && txCmd == 8'h04))
    else $error("Good read not followed by assign");
  chk_assign_pool: assert property (assignDone |->
    usedPool[assignAddr])
    else $error("Assigned address missing from pool");
  chk_read_gap: assert property (gap_q <= GAP_CYC)
    else $error("Read gap too long");
  chk_notify_read: assert property (pkt && pktNotify &&
    pktData == 16'h0000 |-> ##[1:2] (txValid && txCmd == 8'h03))
    else $error("Notify did not start a read");
  chk_other_pass: assert property (pkt &&
    !(pktNotify && pktData == 16'h0000) |-> ##[1:2] pktPass)
    else $error("Other packet not passed on");
  cov_assign: cover property (assignDone);
  cov_pass: cover property (pktPass);
  cov_abort: cover property (runAbort);
endmodule // arp_seq_checker

bind smbus_arp_master_sequencer arp_seq_checker #(.FIXED_MASK(FIXED_MASK),
  .RSVD_MASK(RSVD_MASK), .GAP_CYC(GAP_CYC)) chk (.core_clk, .rst, .txValid,
  .txReady, .txCmd, .txAddr, .txUdid, .rxDone, .rxAllAck, .rxFirst3Ack,
  .rxCount, .rxPecOk, .pktValid, .pktReady, .pktNotify, .pktData, .pktPass,
  .busy, .runDone, .runAbort, .assignDone, .assignAddr, .usedPool);
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam [127:0] BASE = 128'h10F; // Reserved 0..3, fixed 8
  logic core_clk = 0, rst = 1, workState = 0, statusChange = 0;
  logic pktValid = 0, pktNotify = 0, devOn = 1, badCount = 0;
  logic nackAssign = 0;
  logic [15:0] pktData = 16'h0000;
  logic [7:0] lat = 8'h00, devAddr = 8'hFF, log_q [0:15];
  logic [127:0] devId = '0, sentId;
  logic [6:0] gotAddr;
  integer n = 0, nAsg = 0, nPass = 0, nAbort = 0;
  integer bad_count = 0, total_checks = 0;
  wire txValid, txReady, rxDone, rxAllAck, rxFirst3Ack, rxPecOk;
  wire pktReady, pktPass, busy, runDone, runAbort, assignDone;
  wire [7:0] txCmd, txNewAddr, rxCount, rxDevAddr;
  wire [6:0] txAddr, assignAddr;
  wire [127:0] txUdid, rxUdid, usedPool;
  smbus_arp_master_sequencer #(.FIXED_MASK(128'h100), .RSVD_MASK(128'hF),
    .GAP_CYC(200), .PERIOD_CYC(2000)) dut (.core_clk, .rst, .workState,
    .statusChange, .txValid, .txReady, .txCmd, .txAddr, .txUdid,
    .txNewAddr, .rxDone, .rxAllAck, .rxFirst3Ack, .rxCount, .rxPecOk,
    .rxUdid, .rxDevAddr, .pktValid, .pktReady, .pktNotify, .pktData,
    .pktPass, .busy, .runDone, .runAbort, .assignDone, .assignAddr,
    .usedPool);
  arp_far_end_model far (.core_clk, .rst, .lat, .devOn, .devId, .devAddr,
    .badCount, .nackAssign, .txValid, .txCmd, .txAddr, .txUdid, .txReady,
    .rxDone, .rxAllAck, .rxFirst3Ack, .rxCount, .rxPecOk, .rxUdid,
    .rxDevAddr);
  always #50 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////
  // Log up to 16 accepted commands and count the event pulses
  always @(posedge core_clk) begin
    if (txValid && txReady && n < 16) begin
      log_q[n] <= txCmd;
      n <= n + 1;
    end
    if (txValid && txReady && txCmd == 8'h04) sentId <= txUdid;
    if (assignDone) gotAddr <= assignAddr;
    nAsg <= nAsg + assignDone;
    nPass <= nPass + pktPass;
    nAbort <= nAbort + runAbort;
  end
  task automatic check(input logic [127:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic tick(input integer k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait: a hung run shows up as a missing end pulse
  task automatic start(input logic ws, input logic [127:0] id,
      input logic [7:0] a);
    integer i;
    devId = id;
    devAddr = a;
    n = 0;
    nAsg = 0;
    if (ws) workState = 1;
    else statusChange = !statusChange;
    for (i = 0; i < 5000 && runDone !== 1'b1; i++) tick(1);
    check(runDone, 1'b1);
    check(busy, 1'b0);
    tick(2);
  endtask
  task automatic enum_one(input logic ws, input logic [127:0] id,
      input logic [7:0] a, input logic [6:0] e);
    start(ws, id, a);
    check(log_q[0], 8'h01);
    check(log_q[1], 8'h03);
    check(log_q[2], 8'h04);
    check(log_q[3], 8'h03);
    check(gotAddr, e);
    check(txNewAddr, {e, 1'b0});
    check(sentId, id);
    check(usedPool, BASE | (128'h1 << e));
    check(nAsg, 1);
  endtask
  task t_fresh; enum_one(1, {2'b11, 126'hABC}, 8'hFF, 7'h04); endtask
  task t_fixed; enum_one(0, {2'b00, 126'h123}, 8'h11, 7'h08); endtask
  task t_keep; enum_one(0, {2'b01, 126'h456}, 8'h41, 7'h20); endtask
  task t_clash; enum_one(0, {2'b01, 126'h789}, 8'h11, 7'h04); endtask
  task automatic t_faults;
    devOn = 0;
    start(0, 0, 8'hFF);
    check(n, 3);
    devOn = 1;
    badCount = 1;
    start(0, 0, 8'hFF);
    check(n, 2);
    badCount = 0;
    nackAssign = 1;
    start(0, {2'b11, 126'hDEF}, 8'hFF);
    check(n, 6);
    check(log_q[5], 8'h03);
    check(nAsg, 0);
    nackAssign = 0;
  endtask
  task automatic send_pkt(input logic nt, input logic [15:0] d);
    pktValid = 1;
    pktNotify = nt;
    pktData = d;
    while (pktReady !== 1'b1) tick(1);
    tick(1);
    pktValid = 0;
    tick(3);
  endtask
  task automatic t_packets;
    send_pkt(1, 16'h0001);
    send_pkt(0, 16'h0000);
    check(nPass, 2);
    n = 0;
    send_pkt(1, 16'h0000);
    tick(20);
    check(log_q[0], 8'h03);
  endtask
  task automatic t_timeout;
    lat = 8'd250;
    start(0, 0, 8'hFF);
    check(nAbort, 1);
    lat = 8'd0;
    n = 0;
    tick(2400);
    check(n != 0, 1'b1);
    // That rescan resolved the slave, so the next one is a plain read
    n = 0;
    tick(2100);
    check(n, 1);
    check(log_q[0], 8'h03);
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    stop_test;
  end
  initial begin
    tick(12);
    rst = 0;
    tick(1);
    check(usedPool, BASE);
    tick(4);
    t_fresh;
    t_fixed;
    lat = 8'd3;
    t_keep;
    lat = 8'd0;
    t_clash;
    t_faults;
    t_packets;
    t_timeout;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
